// *** rtl/cte_pkg.sv ***
// package for the core timing and exception entry sequencer
// assumes one 100 MHz clock, synchronous active-high reset, an apb master
//
// Contract
// - trap 18 cycles 1r/2w, control move 11 cycles 1w, status move 9
// - immediate status move with bit 13 set finishes in one cycle
// - multi-register transfer takes 2+n cycles, n reads or n writes
// - pc-relative push address timing equals address-register modes, indexed 3
// - stop counts 3 cycles until continuous interrupt sampling begins
// - exception return 14/2r, subroutine return 8/1r, indirect jump 5
// - accelerated branch, call, absolute jump take 1 to 3 cycles
// - forward conditional branch predicted not taken when ccr bit 7 clear
// - backward conditional branch always predicted taken
// - correct prediction takes 1 cycle, misprediction takes 5
// - exceptions restart the faulting instruction afterwards
// - exception entry spans fault detection to handler fetch start
// - entry copies status word, sets supervisor, clears trace
// - interrupts also clear master bit and load mask with level
// - non-interrupt vector number derived from exception type
// - interrupts run an acknowledge cycle; responder supplies the vector
// - acknowledge cycle uses its own space with level in address
// - one stack pointer only, no separate supervisor and user copies
// - stack frame placed at a 0-modulo-4 address on stack top
// - handler fetched from vector base plus four times vector number
package cte_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [11:0] CTE_CMD_OFS    = 12'h000;
	localparam logic [11:0] CTE_STAT_OFS   = 12'h004;
	localparam logic [11:0] CTE_PSW_OFS    = 12'h008;
	localparam logic [11:0] CTE_SP_OFS     = 12'h00C;
	localparam logic [11:0] CTE_VBR_OFS    = 12'h010;
	localparam logic [11:0] CTE_EXC_OFS    = 12'h014;
	localparam logic [11:0] CTE_IRQ_OFS    = 12'h018;
	localparam logic [11:0] CTE_FRAME_OFS  = 12'h01C;
	localparam logic [11:0] CTE_HVEC_OFS   = 12'h020;
	localparam logic [11:0] CTE_ACKVEC_OFS = 12'h024;

	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam int CTE_PSW_TRACE = 15;
	localparam int CTE_PSW_SUP   = 13;
	localparam int CTE_PSW_MST   = 12;
	localparam int CTE_PSW_MLO   = 8;
	localparam int CTE_CCR_B7    = 7;
	localparam int CTE_IMM_FAST  = 13;
	localparam logic [15:0] CTE_PSW_RST = 16'h2700;
	localparam logic [31:0] CTE_SP_RST  = 32'h0000_0000;
	localparam logic [31:0] CTE_ACK_SPACE = 32'hFFFF_FFE0;
	localparam logic [7:0]  CTE_VEC_AUTO  = 8'h18;

	// ------------------------------------------------------------
	// timing counts in core cycles
	// ------------------------------------------------------------
	localparam logic [7:0] CTE_T_TRAP   = 8'h12;
	localparam logic [7:0] CTE_T_MOVEC  = 8'h0B;
	localparam logic [7:0] CTE_T_PSW    = 8'h09;
	localparam logic [7:0] CTE_T_FAST   = 8'h01;
	localparam logic [7:0] CTE_T_MULTI  = 8'h02;
	localparam logic [7:0] CTE_T_PEAX   = 8'h03;
	localparam logic [7:0] CTE_T_STOP   = 8'h03;
	localparam logic [7:0] CTE_T_RTE    = 8'h0E;
	localparam logic [7:0] CTE_T_RTS    = 8'h08;
	localparam logic [7:0] CTE_T_JMPI   = 8'h05;
	localparam logic [7:0] CTE_T_MISS   = 8'h05;
	localparam logic [7:0] CTE_T_ACC_HI = 8'h03;

	// ------------------------------------------------------------
	// instruction classes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		CTE_OP_TRAP   = 4'h0,
		CTE_OP_MOVEC  = 4'h1,
		CTE_OP_PSWREG = 4'h2,
		CTE_OP_PSWIMM = 4'h3,
		CTE_OP_LDM    = 4'h4,
		CTE_OP_STM    = 4'h5,
		CTE_OP_PEAX   = 4'h6,
		CTE_OP_STOP   = 4'h7,
		CTE_OP_RTE    = 4'h8,
		CTE_OP_RTS    = 4'h9,
		CTE_OP_JMPI   = 4'hA,
		CTE_OP_ACCEL  = 4'hB,
		CTE_OP_BCC    = 4'hC
	} cte_op_t;

	typedef struct packed {
		logic [7:0] cycles;
		logic [4:0] reads;
		logic [4:0] writes;
	} cte_cost_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} cte_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} cte_apb_rsp_t;

	typedef struct packed {
		logic        req;
		logic [31:0] addr;
		logic [2:0]  level;
	} cte_ack_t;

endpackage

// *** rtl/cte_core.sv ***
// instruction timing, branch prediction and exception entry sequencer
// assumes an apb master for control and a peripheral answering ack cycles
//
// Our own choices: the APB interface to the registers and the placing of the registers.
module cte_core (
	input  wire logic            mclk,
	input  wire logic            rst,
	input  wire cte_pkg::cte_apb_req_t apb_req,
	output      cte_pkg::cte_apb_rsp_t apb_rsp,
	output      cte_pkg::cte_ack_t     ack_out,
	input  wire logic            ack_valid,
	input  wire logic [7:0]      ack_vector,
	output      logic            rd_pulse,
	output      logic            wr_pulse,
	output      logic            busy,
	output      logic            handler_fetch
);
	import cte_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef enum logic [5:0] {
		CTE_IDLE  = 6'b000001,
		CTE_EXEC  = 6'b000010,
		CTE_SAVE  = 6'b000100,
		CTE_ACK   = 6'b001000,
		CTE_FRAME = 6'b010000,
		CTE_FETCH = 6'b100000
	} cte_state_t;

	cte_state_t  state_q;
	logic [15:0] psw_q;
	logic [15:0] psw_copy_q;
	logic [31:0] sp_q;
	logic [31:0] vbr_q;
	logic [31:0] frame_q;
	logic [31:0] hvec_q;
	logic [7:0]  vec_q;
	logic [7:0]  cnt_q;
	logic [4:0]  rd_left_q;
	logic [4:0]  wr_left_q;
	logic        irq_pend_q;
	logic [2:0]  irq_lvl_q;
	logic [2:0]  svc_lvl_q;
	logic        exc_is_irq_q;
	logic [5:0]  exc_type_q;
	logic        pred_taken_q;
	logic        stopped_q;
	logic        stop_op_q;
	logic [7:0]  last_cycles_q;
	logic        go_cmd;
	logic        exc_cmd;
	logic        wr_acc;
	logic        rd_acc;
	logic        irq_take;
	cte_cost_t   cost;

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic cte_cost_t cost_of(input logic [3:0] op,
		input logic [15:0] arg, input logic [15:0] psw);
		cte_cost_t c;
		logic      fwd;
		logic      pred;
		c = '{cycles: CTE_T_FAST, reads: 5'd0, writes: 5'd0};
		fwd  = ~arg[15];
		pred = ~(fwd & ~psw[CTE_CCR_B7]);
		unique case (op)
			CTE_OP_TRAP:   c = '{CTE_T_TRAP, 5'd1, 5'd2};
			CTE_OP_MOVEC:  c = '{CTE_T_MOVEC, 5'd0, 5'd1};
			CTE_OP_PSWREG: c = '{CTE_T_PSW, 5'd0, 5'd0};
			CTE_OP_PSWIMM: c = '{arg[CTE_IMM_FAST] ? CTE_T_FAST
				: CTE_T_PSW, 5'd0, 5'd0};
			CTE_OP_LDM:    c = '{CTE_T_MULTI + {3'd0, arg[4:0]},
				arg[4:0], 5'd0};
			CTE_OP_STM:    c = '{CTE_T_MULTI + {3'd0, arg[4:0]},
				5'd0, arg[4:0]};
			CTE_OP_PEAX:   c = '{CTE_T_PEAX, 5'd0, 5'd1};
			CTE_OP_STOP:   c = '{CTE_T_STOP, 5'd0, 5'd0};
			CTE_OP_RTE:    c = '{CTE_T_RTE, 5'd2, 5'd0};
			CTE_OP_RTS:    c = '{CTE_T_RTS, 5'd1, 5'd0};
			CTE_OP_JMPI:   c = '{CTE_T_JMPI, 5'd0, 5'd0};
			CTE_OP_ACCEL:  c = '{(arg[1:0] == 2'd0) ? CTE_T_FAST
				: ((arg[1:0] > 2'd2) ? CTE_T_ACC_HI
				: {6'd0, arg[1:0]}), 5'd0, 5'd0};
			CTE_OP_BCC:    c = '{(pred == arg[14]) ? CTE_T_FAST
				: CTE_T_MISS, 5'd0, 5'd0};
			default:       c = '{CTE_T_FAST, 5'd0, 5'd0};
		endcase
		return c;
	endfunction

	// forward with ccr bit 7 clear -> not taken, backward -> taken
	function automatic logic predict(input logic bwd, input logic [15:0] psw);
		return bwd | psw[CTE_CCR_B7];
	endfunction

	// ------------------------------------------------------------
	// apb slave: one wait state, slverr on unmapped
	// ------------------------------------------------------------
	assign rd_acc  = apb_req.psel & apb_req.penable & ~apb_req.pwrite
		& ~apb_rsp.pready;
	assign wr_acc  = apb_req.psel & apb_req.penable & apb_req.pwrite
		& ~apb_rsp.pready;
	assign go_cmd  = wr_acc & (apb_req.paddr == CTE_CMD_OFS)
		& (state_q == CTE_IDLE);
	assign exc_cmd = wr_acc & (apb_req.paddr == CTE_EXC_OFS)
		& (state_q == CTE_IDLE);
	assign cost    = cost_of(apb_req.pwdata[19:16], apb_req.pwdata[15:0],
		psw_q);

	always_ff @(posedge mclk) begin
		if (rst) begin
			apb_rsp <= '0;
		end else begin
			apb_rsp.pready  <= apb_req.psel & apb_req.penable
				& ~apb_rsp.pready;
			apb_rsp.pslverr <= 1'b0;
			if (rd_acc) begin
				unique case (apb_req.paddr)
					CTE_STAT_OFS:   apb_rsp.prdata <= {5'd0,
						state_q,
						pred_taken_q,
						stopped_q,
						irq_pend_q,
						rd_left_q,
						wr_left_q,
						last_cycles_q};
					CTE_PSW_OFS:    apb_rsp.prdata <= {psw_copy_q, psw_q};
					CTE_SP_OFS:     apb_rsp.prdata <= sp_q;
					CTE_VBR_OFS:    apb_rsp.prdata <= vbr_q;
					CTE_FRAME_OFS:  apb_rsp.prdata <= frame_q;
					CTE_HVEC_OFS:   apb_rsp.prdata <= hvec_q;
					CTE_ACKVEC_OFS: apb_rsp.prdata <= {24'd0, vec_q};
					default: begin
						apb_rsp.prdata  <= 32'h0000_0000;
						apb_rsp.pslverr <= 1'b1;
					end
				endcase
			end else if (wr_acc) begin
				apb_rsp.prdata  <= 32'h0000_0000;
				apb_rsp.pslverr <= ~(apb_req.paddr inside {CTE_CMD_OFS,
					CTE_PSW_OFS, CTE_SP_OFS, CTE_VBR_OFS, CTE_EXC_OFS,
					CTE_IRQ_OFS});
			end
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	// interrupts are weighed only while idle, so one raised during an
	// entry waits until that entry has started its handler fetch
	assign irq_take = (state_q == CTE_IDLE) & ~go_cmd & ~exc_cmd
		& irq_pend_q
		& ((irq_lvl_q > psw_q[CTE_PSW_MLO +: 3])
		| (irq_lvl_q == 3'd7));

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= CTE_IDLE;
		end else begin
			unique case (state_q)
				CTE_IDLE: begin
					if (go_cmd) begin
						state_q <= CTE_EXEC;
					end else if (exc_cmd || irq_take) begin
						state_q <= CTE_SAVE;
					end
				end
				CTE_EXEC: begin
					if (cnt_q == 8'h01) begin
						state_q <= CTE_IDLE;
					end
				end
				CTE_SAVE: begin
					state_q <= exc_is_irq_q ? CTE_ACK : CTE_FRAME;
				end
				CTE_ACK: begin
					if (ack_valid) begin
						state_q <= CTE_FRAME;
					end
				end
				CTE_FRAME: state_q <= CTE_FETCH;
				CTE_FETCH: state_q <= CTE_IDLE;
				default:   state_q <= CTE_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// cycle and operand access counters
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q         <= 8'h00;
			rd_left_q     <= 5'd0;
			wr_left_q     <= 5'd0;
			last_cycles_q <= 8'h00;
		end else if (go_cmd) begin
			cnt_q         <= cost.cycles;
			last_cycles_q <= cost.cycles;
			rd_left_q     <= cost.reads;
			wr_left_q     <= cost.writes;
		end else if (state_q == CTE_EXEC) begin
			// one operand access per cycle, reads first
			cnt_q <= cnt_q - 8'h01;
			if (rd_left_q != 5'd0) begin
				rd_left_q <= rd_left_q - 5'd1;
			end else if (wr_left_q != 5'd0) begin
				wr_left_q <= wr_left_q - 5'd1;
			end
		end
	end

	// ------------------------------------------------------------
	// stop and prediction flags
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			stop_op_q    <= 1'b0;
			stopped_q    <= 1'b0;
			pred_taken_q <= 1'b0;
		end else if (go_cmd) begin
			stop_op_q    <= apb_req.pwdata[19:16] == CTE_OP_STOP;
			stopped_q    <= 1'b0;
			pred_taken_q <= predict(apb_req.pwdata[15], psw_q);
		end else if (state_q == CTE_EXEC && cnt_q == 8'h01) begin
			// the op is latched at issue: the bus is idle by now
			stopped_q <= stop_op_q;
		end else if (irq_take) begin
			stopped_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// exception source
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			exc_is_irq_q <= 1'b0;
			exc_type_q   <= 6'd0;
			svc_lvl_q    <= 3'd0;
		end else if (exc_cmd) begin
			exc_is_irq_q <= 1'b0;
			exc_type_q   <= apb_req.pwdata[5:0];
		end else if (irq_take) begin
			// frozen here so a newer request cannot move the ack address
			exc_is_irq_q <= 1'b1;
			svc_lvl_q    <= irq_lvl_q;
		end
	end

	// ------------------------------------------------------------
	// status word, stack pointer, vector and frame
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			psw_q      <= CTE_PSW_RST;
			psw_copy_q <= 16'h0000;
			sp_q       <= CTE_SP_RST;
			vbr_q      <= 32'h0000_0000;
			frame_q    <= 32'h0000_0000;
			hvec_q     <= 32'h0000_0000;
			vec_q      <= 8'h00;
		end else begin
			if (wr_acc && state_q == CTE_IDLE) begin
				if (apb_req.paddr == CTE_PSW_OFS)
					psw_q <= apb_req.pwdata[15:0];
				if (apb_req.paddr == CTE_SP_OFS)
					sp_q <= apb_req.pwdata;
				if (apb_req.paddr == CTE_VBR_OFS)
					vbr_q <= {apb_req.pwdata[31:20], 20'h0_0000};
			end
			if (state_q == CTE_SAVE) begin
				psw_copy_q <= psw_q;
				psw_q[CTE_PSW_SUP]   <= 1'b1;
				psw_q[CTE_PSW_TRACE] <= 1'b0;
				if (exc_is_irq_q) begin
					psw_q[CTE_PSW_MST] <= 1'b0;
					psw_q[CTE_PSW_MLO +: 3] <= svc_lvl_q;
				end else begin
					vec_q <= {2'b00, exc_type_q};
				end
			end
			if (state_q == CTE_ACK && ack_valid)
				vec_q <= ack_vector;
			if (state_q == CTE_FRAME) begin
				// two longwords below the longword-aligned top
				frame_q <= {sp_q[31:2], 2'b00} - 32'h0000_0008;
				sp_q    <= {sp_q[31:2], 2'b00} - 32'h0000_0008;
			end
			if (state_q == CTE_FETCH)
				hvec_q <= vbr_q + {22'd0, vec_q, 2'b00};
		end
	end

	// ------------------------------------------------------------
	// interrupt capture: held until the entry is taken
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_pend_q <= 1'b0;
			irq_lvl_q  <= 3'd0;
		end else begin
			// set wins over the clear taken at entry
			if (wr_acc && apb_req.paddr == CTE_IRQ_OFS
				&& apb_req.pwdata[2:0] != 3'd0) begin
				irq_pend_q <= 1'b1;
				irq_lvl_q  <= apb_req.pwdata[2:0];
			end else if (irq_take) begin
				irq_pend_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			ack_out       <= '0;
			rd_pulse      <= 1'b0;
			wr_pulse      <= 1'b0;
			busy          <= 1'b0;
			handler_fetch <= 1'b0;
		end else begin
			ack_out.req   <= (state_q == CTE_SAVE && exc_is_irq_q)
				| (state_q == CTE_ACK && !ack_valid);
			ack_out.addr  <= CTE_ACK_SPACE | {27'd0, svc_lvl_q, 2'b00};
			ack_out.level <= svc_lvl_q;
			rd_pulse      <= state_q == CTE_EXEC && rd_left_q != 5'd0;
			wr_pulse      <= state_q == CTE_EXEC && rd_left_q == 5'd0
				&& wr_left_q != 5'd0;
			busy          <= state_q != CTE_IDLE;
			handler_fetch <= state_q == CTE_FETCH;
		end
	end

endmodule

// *** verification/cte_core_chk.sv ***
// port checker for the timing and exception entry sequencer
// assumes one clock and a synchronous active-high reset
module cte_core_chk (
	input wire logic                  mclk,
	input wire logic                  rst,
	input wire cte_pkg::cte_apb_req_t apb_req,
	input wire cte_pkg::cte_apb_rsp_t apb_rsp,
	input wire cte_pkg::cte_ack_t     ack_out,
	input wire logic                  ack_valid,
	input wire logic [7:0]            ack_vector,
	input wire logic                  rd_pulse,
	input wire logic                  wr_pulse,
	input wire logic                  busy,
	input wire logic                  handler_fetch
);
	import cte_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// ----
	// properties
	// ----
	chk_apb_wait: assert property (apb_req.psel && apb_req.penable
		&& !apb_rsp.pready |=> apb_rsp.pready) else $error("pready late");
	chk_apb_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready held");
	chk_ack_space: assert property (
		ack_out.req |-> ack_out.addr[31:5] == CTE_ACK_SPACE[31:5])
		else $error("ack address outside space");
	chk_ack_level: assert property (
		ack_out.req |-> ack_out.addr[4:2] == ack_out.level)
		else $error("ack address level wrong");
	chk_ack_stable: assert property (
		ack_out.req && $past(ack_out.req) |-> $stable(ack_out.addr))
		else $error("ack address moved");
	chk_ack_hold: assert property (
		ack_out.req && !ack_valid |=> ack_out.req)
		else $error("ack dropped unanswered");
	chk_ack_entry: assert property (
		ack_out.req && ack_valid |-> ##[1:4] handler_fetch)
		else $error("no handler fetch after ack");
	chk_ack_nested: assert property (
		ack_out.req && ack_valid |=> !ack_out.req [*3])
		else $error("new ack inside entry");
	chk_fetch_pulse: assert property (
		handler_fetch |=> !handler_fetch) else $error("fetch pulse long");
	chk_rd_first: assert property (
		wr_pulse |-> !rd_pulse ##1 !rd_pulse)
		else $error("read after write");
endmodule

bind cte_core cte_core_chk cte_core_chk_i (.mclk(mclk), .rst(rst),
	.apb_req(apb_req), .apb_rsp(apb_rsp), .ack_out(ack_out),
	.ack_valid(ack_valid), .ack_vector(ack_vector), .rd_pulse(rd_pulse),
	.wr_pulse(wr_pulse), .busy(busy), .handler_fetch(handler_fetch));

// *** verification/cte_irq_peer.sv ***
// interrupting peripheral answering acknowledge cycles
// assumes vector = vbase + level; delay sets how slowly it answers
module cte_irq_peer (
	input wire logic              mclk,
	input wire logic              rst,
	input wire logic [3:0]        delay,
	input wire cte_pkg::cte_ack_t ack_in,
	output     logic              ack_valid,
	output     logic [7:0]        ack_vector
);
	import cte_pkg::*;
	localparam logic [7:0] VBASE = 8'h40;
	logic [3:0] wait_q;
	logic [7:0] last_q;
	logic       hit;
	// ----
	// decode and answer
	// ----
	assign hit = ack_in.req && ack_in.addr ==
		(CTE_ACK_SPACE | {27'h000_0000, ack_in.level, 2'b00});
	always_ff @(posedge mclk) begin
		if (rst || !hit) begin
			wait_q    <= 4'h0;
			ack_valid <= 1'b0;
		end else if (wait_q >= delay) begin
			ack_valid <= 1'b1;
		end else begin
			wait_q <= wait_q + 4'h1;
		end
	end
	// released bus shows the inverse so stale values never match
	assign ack_vector = ack_valid ? VBASE + {5'h00, ack_in.level} : ~last_q;
	always_ff @(posedge mclk) begin
		if (rst)
			last_q <= 8'h00;
		else if (ack_valid)
			last_q <= ack_vector;
	end
endmodule

// *** verification/cte_core_test.sv ***
// self-checking bench for the timing and exception entry sequencer
// assumes apb access with one wait state and the peer model
module cte_core_test;
	timeunit 1ns;
	timeprecision 1ps;
	import cte_pkg::*;
	logic         mclk = 1'b0;
	logic         rst = 1'b1;
	cte_apb_req_t apb_req = '0;
	cte_apb_rsp_t apb_rsp;
	cte_ack_t     ack_out;
	logic         ack_valid, rd_pulse, wr_pulse, busy, handler_fetch, err;
	logic [7:0]   ack_vector;
	logic [3:0]   delay = 4'h0;
	logic [31:0]  rdata;
	logic [2:0]   lv [$];
	int           bad_count = 0, n_tests = 0, cyc = 0, nb, nr, nw, nf;

	cte_core cte_core_i (.mclk(mclk), .rst(rst), .apb_req(apb_req),
		.apb_rsp(apb_rsp), .ack_out(ack_out), .ack_valid(ack_valid),
		.ack_vector(ack_vector), .rd_pulse(rd_pulse), .wr_pulse(wr_pulse),
		.busy(busy), .handler_fetch(handler_fetch));
	cte_irq_peer cte_irq_peer_i (.mclk(mclk), .rst(rst), .delay(delay),
		.ack_in(ack_out), .ack_valid(ack_valid), .ack_vector(ack_vector));

	always #5 mclk = ~mclk;
	// ----
	// shared tasks
	// ----
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end
	task automatic check(input string what, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s exp %h got %h", what, e, g);
		end
	endtask
	// holds the request until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge mclk);
		apb_req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:d};
		@(posedge mclk);
		apb_req.penable <= 1'b1;
		do @(posedge mclk); while (apb_rsp.pready !== 1'b1);
		rdata = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req <= '0;
	endtask
	task automatic run_op(input cte_op_t op, input logic [15:0] arg,
		input int c, input int r, input int w);
		nb = 0;
		nr = 0;
		nw = 0;
		apb(1'b1, CTE_CMD_OFS, {12'h000, op, arg});
		repeat (40) begin
			@(negedge mclk);
			nb += (busy === 1'b1);
			nr += (rd_pulse === 1'b1);
			nw += (wr_pulse === 1'b1);
		end
		check("cycles", c, nb);
		check("reads", r, nr);
		check("writes", w, nw);
	endtask
	task automatic wait_fetch(input int n);
		nf = 0;
		repeat (60) begin
			@(negedge mclk);
			nf += (handler_fetch === 1'b1);
			if (ack_out.req === 1'b1 && ack_valid === 1'b1)
				lv.push_back(ack_out.level);
		end
		check("fetches", n, nf);
	endtask
	// ----
	// scenarios
	// ----
	task automatic reset_test();
		apb(1'b0, CTE_PSW_OFS, 32'h0);
		check("psw reset", 32'h0000_2700, rdata & 32'h0000_FFFF);
		apb(1'b0, CTE_SP_OFS, 32'h0);
		check("sp reset", 32'h0000_0000, rdata);
		apb(1'b0, 12'h0FC, 32'h0);
		check("slverr", 32'h1, {31'h0, err});
	endtask
	task automatic op_test();
		run_op(CTE_OP_TRAP, 16'h0000, 18, 1, 2);
		run_op(CTE_OP_MOVEC, 16'h0000, 11, 0, 1);
		run_op(CTE_OP_LDM, 16'h0005, 7, 5, 0);
		run_op(CTE_OP_STM, 16'h0001, 3, 0, 1);
		run_op(CTE_OP_PEAX, 16'h0000, 3, 0, 1);
		run_op(CTE_OP_RTE, 16'h0000, 14, 2, 0);
		run_op(CTE_OP_RTS, 16'h0000, 8, 1, 0);
		run_op(CTE_OP_JMPI, 16'h0000, 5, 0, 0);
		for (int i = 0; i < 4; i++)
			run_op(CTE_OP_ACCEL, i[15:0], i == 0 ? 1 : i, 0, 0);
		run_op(CTE_OP_BCC, 16'hC000, 1, 0, 0);
		run_op(CTE_OP_BCC, 16'h8000, 5, 0, 0);
		run_op(CTE_OP_BCC, 16'h0000, 1, 0, 0);
		run_op(CTE_OP_BCC, 16'h4000, 5, 0, 0);
		run_op(CTE_OP_PSWREG, 16'h2700, 9, 0, 0);
		run_op(CTE_OP_PSWIMM, 16'h2700, 1, 0, 0);
		run_op(CTE_OP_PSWIMM, 16'h0700, 9, 0, 0);
		run_op(CTE_OP_STOP, 16'h2700, 3, 0, 0);
		apb(1'b0, CTE_STAT_OFS, 32'h0);
		check("stat stop", 32'h0028_0003, rdata);
	endtask
	task automatic exc_test();
		apb(1'b1, CTE_PSW_OFS, 32'h0000_9300);
		apb(1'b1, CTE_SP_OFS, 32'h0000_1003);
		apb(1'b1, CTE_VBR_OFS, 32'h0012_3456);
		apb(1'b0, CTE_VBR_OFS, 32'h0);
		check("vbr", 32'h0010_0000, rdata);
		apb(1'b1, CTE_EXC_OFS, 32'h0000_0004);
		wait_fetch(1);
		apb(1'b0, CTE_PSW_OFS, 32'h0);
		check("psw exc", 32'h9300_3300, rdata);
		apb(1'b0, CTE_SP_OFS, 32'h0);
		check("sp exc", 32'h0000_0FF8, rdata);
		apb(1'b0, CTE_FRAME_OFS, 32'h0);
		check("frame", 32'h0000_0FF8, rdata);
		apb(1'b0, CTE_HVEC_OFS, 32'h0);
		check("hvec", 32'h0010_0010, rdata);
	endtask
	task automatic irq_test();
		@(posedge mclk);
		delay <= 4'h6;
		apb(1'b1, CTE_PSW_OFS, 32'h0000_9300);
		apb(1'b1, CTE_SP_OFS, 32'h0000_2000);
		lv.delete();
		apb(1'b1, CTE_IRQ_OFS, 32'h0000_0005);
		apb(1'b1, CTE_IRQ_OFS, 32'h0000_0006);
		wait_fetch(2);
		check("ack count", 32'h2, lv.size());
		if (lv.size() == 2)
			check("ack levels", 32'h2E, {26'h0, lv[0], lv[1]});
		apb(1'b0, CTE_PSW_OFS, 32'h0);
		check("psw irq", 32'h2500_2600, rdata);
		apb(1'b0, CTE_SP_OFS, 32'h0);
		check("sp irq", 32'h0000_1FF0, rdata);
		apb(1'b0, CTE_HVEC_OFS, 32'h0);
		check("hvec irq", 32'h0010_0118, rdata);
		apb(1'b0, CTE_ACKVEC_OFS, 32'h0);
		check("ackvec", 32'h0000_0046, rdata);
		@(posedge mclk);
		delay <= 4'h0;
		apb(1'b1, CTE_IRQ_OFS, 32'h0000_0002);
		wait_fetch(0);
		apb(1'b1, CTE_IRQ_OFS, 32'h0000_0007);
		wait_fetch(1);
	endtask

	initial begin
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		reset_test();
		op_test();
		exc_test();
		irq_test();
		final_report();
	end
endmodule
